// ==== core/ptr_pkg.sv ====
// Function
// - carrier clock drives all bit and modulation timing
// - hold logic in reset until supply good
// - flag gap after field absent set cycles
// - gap event enters anti-collision mode
// - coil transistor follows modulation signal
// - configuration word never changed over link
// - configuration bit eleven always reads one; here it reads zero until capture forces it to one
// - lock after programming, then refuse programming
// - bits two to four pick bit length
// - code 0,1,1 gives 32 carrier cycles
// - default and programming use 128 cycles
// - timing settings ignored until lock set
// - encode memory stream per bits six, seven
// - NRZ, differential, Manchester, inverted Manchester
// - unlocked: 128 cycles, FSK, direct coding
// - lock bit is MSB, bit one LSB
package ptr_pkg;

  // configuration word layout, bit one at index zero
  localparam int CFG_W         = 12;
  localparam int CFG_LEN_BIT   = 0;
  localparam int CFG_RATE_LO   = 1;
  localparam int CFG_ENC_LO    = 5;
  localparam int CFG_MOD_LO    = 7;
  localparam int CFG_FIXED_ONE = 10;
  localparam int CFG_LOCK      = 11;

  // bit period counting
  localparam int            CNT_W        = 8;
  localparam logic [CNT_W-1:0] DIV128_BIT_RATE = 8'h80;
  localparam logic [CNT_W-1:0] DIV32_BIT_RATE  = 8'h20;
  localparam logic [2:0]    RATE_DIV32   = 3'h6;
  localparam logic [2:0]    RATE_DIV50   = 3'h5;
  localparam logic [1:0]    MOD_FSK      = 2'h0;

  // fsk sets in carrier cycles
  localparam logic [3:0] FSK_HIGH_SET = 4'ha;
  localparam logic [3:0] FSK_LOW_SET  = 4'h8;

  // gap detection timing on the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int GAP_DETECT_NS = 30000;
  localparam int GAP_CYCLES    = GAP_DETECT_NS / CLK_PERIOD_NS;
  localparam int GAP_W         = 12;
  localparam logic [1:0] CFG_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    ENC_NRZ            = 2'b00,
    ENC_BIPHASE_S      = 2'b01,
    ENC_MANCHESTER     = 2'b10,
    ENC_INV_MANCHESTER = 2'b11
  } ptr_enc_type;

  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_NATIVE  = 2'b01,
    ST_LOCKED  = 2'b10
  } ptr_state_type;

  typedef struct packed {
    logic [CNT_W-1:0] bit_cycles;
    ptr_enc_type      enc;
    logic             fsk;
  } ptr_settings_type;

  // carrier cycles per bit from the rate code {bit4,bit3,bit2}
  function automatic logic [CNT_W-1:0] rate_cycles(input logic [2:0] code);
    case (code)
      RATE_DIV32: rate_cycles = DIV32_BIT_RATE;
      RATE_DIV50: rate_cycles = 8'h32;
      3'h0:       rate_cycles = DIV128_BIT_RATE;
      3'h1:       rate_cycles = 8'h64;
      3'h2:       rate_cycles = 8'h50;
      3'h3:       rate_cycles = 8'h40;
      3'h4:       rate_cycles = 8'h28;
      default:    rate_cycles = 8'h10;
    endcase
  endfunction

endpackage

// ==== core/ptr_bit_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptr_bit_timer
  import ptr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [CNT_W-1:0] bit_cycles,
  output logic                  bit_start,
  output logic                  half_start
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;

  assign last = bit_cycles - 8'h01;

  // bit period counter, wraps at each boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (count >= last) begin
      count <= '0;
    end else begin
      count <= count + 8'h01;
    end
  end

  // boundary and mid-bit marks
  assign bit_start  = (count == '0);
  assign half_start = (count == {1'b0, bit_cycles[CNT_W-1:1]});

endmodule
`default_nettype wire

// ==== core/ptr_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptr_encoder
  import ptr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire ptr_enc_type method,
  input  wire logic        bit_start,
  input  wire logic        half_start,
  input  wire logic        data,
  output logic             level
);

  logic held;

  // data bit held for the whole bit period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
    end else if (bit_start) begin
      held <= data;
    end
  end

  // line level per coding method
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else begin
      case (method)
        ENC_NRZ: begin
          if (bit_start) level <= data;
        end
        ENC_BIPHASE_S: begin
          if (bit_start) level <= ~level;
          else if (half_start && !held) level <= ~level;
        end
        ENC_MANCHESTER: begin
          if (bit_start) level <= data;
          else if (half_start) level <= ~held;
        end
        default: begin
          if (bit_start) level <= ~data;
          else if (half_start) level <= held;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== core/ptr_tag_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptr_tag_control
  import ptr_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             carrier_clock,
  input  wire logic             supply_ok,
  input  wire logic             field_present,
  input  wire logic [CFG_W-1:0] cfg_word,
  input  wire logic             prog_success,
  input  wire logic             mem_data,
  output logic                  mem_step,
  output logic                  coil_pad_short,
  output logic                  gap_event,
  output logic                  anticoll_mode,
  output logic                  array_lock_bit,
  output logic                  prog_allow,
  output logic [CFG_W-1:0]      cfg_effective
);

  // ---- system clock domain ----

  logic [1:0]        rst_sync;
  logic              rst_n;
  logic [1:0]        supply_sync;
  logic              core_rst_n;
  logic [1:0]        field_sync;
  logic [CFG_W-1:0]  cfg_s1;
  logic [CFG_W-1:0]  cfg_s2;
  ptr_state_type     state;
  ptr_state_type     next_state;
  logic [1:0]        settle;
  logic [CFG_W-1:0]  cfg_hold;
  logic [GAP_W-1:0]  gap_count;
  logic              gap_seen;
  ptr_settings_type  want;
  ptr_settings_type  settings_hold;
  logic              req_tog;
  logic [1:0]        ack_sync;

  // ---- carrier domain ----

  logic [1:0]        link_rst_sync;
  logic              link_rst_n;
  logic [2:0]        req_sync;
  logic              ack_tog;
  ptr_settings_type  live;
  logic              bit_start;
  logic              half_start;
  logic              enc_level;
  logic [3:0]        fsk_count;
  logic [3:0]        fsk_set;

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // supply-good and field pins synchronised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_sync <= 2'b00;
      field_sync  <= 2'b11; // field idle level, no false gap count after reset
      cfg_s1      <= '0;
      cfg_s2      <= '0;
    end else begin
      supply_sync <= {supply_sync[0], supply_ok};
      field_sync  <= {field_sync[0], field_present};
      cfg_s1      <= cfg_word;
      cfg_s2      <= cfg_s1;
    end
  end

  // logic held in reset until the supply is good
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rst_n <= 1'b0;
    end else begin
      core_rst_n <= supply_sync[1];
    end
  end

  // configuration settle delay after release
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      settle <= '0;
    end else if (state == ST_CAPTURE && settle != CFG_SETTLE) begin
      settle <= settle + 2'h1;
    end
  end

  // lock state machine next value
  always_comb begin
    next_state = state;
    case (state)
      ST_CAPTURE: begin
        if (settle == CFG_SETTLE) begin
          next_state = cfg_s2[CFG_LOCK] ? ST_LOCKED : ST_NATIVE;
        end
      end
      ST_NATIVE: begin
        if (prog_success) begin
          next_state = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        next_state = ST_LOCKED;
      end
      default: begin
        next_state = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state <= ST_CAPTURE;
    end else begin
      state <= next_state;
    end
  end

  // configuration captured once from the factory pins only
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cfg_hold <= '0;
    end else if (state == ST_CAPTURE && settle == CFG_SETTLE) begin
      cfg_hold                <= cfg_s2;
      cfg_hold[CFG_FIXED_ONE] <= 1'b1;
    end else if (state == ST_NATIVE && prog_success) begin
      cfg_hold[CFG_LOCK] <= 1'b1;
    end
  end

  // lock bit is the top of the word, bit one the bottom
  assign cfg_effective  = cfg_hold;
  assign array_lock_bit = cfg_hold[CFG_LOCK];

  // programming refused once locked or before capture
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      prog_allow <= 1'b0;
    end else begin
      prog_allow <= (next_state == ST_NATIVE);
    end
  end

  // gap counter on the absent field
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      gap_count <= '0;
      gap_seen  <= 1'b0;
      gap_event <= 1'b0;
    end else begin
      gap_event <= 1'b0;
      if (field_sync[1]) begin
        gap_count <= '0;
        gap_seen  <= 1'b0;
      end else if (!gap_seen) begin
        if (gap_count == GAP_W'(GAP_CYCLES - 1)) begin
          gap_seen  <= 1'b1;
          gap_event <= 1'b1;
        end else begin
          gap_count <= gap_count + 12'h001;
        end
      end
    end
  end

  // anti-collision mode entered on a gap
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      anticoll_mode <= 1'b0;
    end else if (gap_event) begin
      anticoll_mode <= 1'b1;
    end
  end

  // settings wanted by the current lock state
  always_comb begin
    if (state == ST_LOCKED) begin
      want.bit_cycles = rate_cycles(cfg_hold[CFG_RATE_LO +: 3]);
      want.enc        = ptr_enc_type'(cfg_hold[CFG_ENC_LO +: 2]);
      want.fsk        = (cfg_hold[CFG_MOD_LO +: 2] == MOD_FSK);
    end else begin
      want.bit_cycles = DIV128_BIT_RATE;
      want.enc        = ENC_NRZ;
      want.fsk        = 1'b1;
    end
  end

  // acknowledge returning from the carrier side
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ack_sync <= 2'b00;
    end else begin
      ack_sync <= {ack_sync[0], ack_tog};
    end
  end

  // settings word sent by toggle handshake, held while pending
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      settings_hold <= '{bit_cycles: DIV128_BIT_RATE, enc: ENC_NRZ, fsk: 1'b1};
      req_tog       <= 1'b0;
    end else if (ack_sync[1] == req_tog && want != settings_hold) begin
      settings_hold <= want;
      req_tog       <= ~req_tog;
    end
  end

  // ---- carrier clock side ----

  // link reset released on the carrier clock
  always_ff @(posedge carrier_clock or negedge core_rst_n) begin
    if (!core_rst_n) begin
      link_rst_sync <= 2'b00;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end

  assign link_rst_n = link_rst_sync[1];

  // request toggle synchronised, word loaded on its edge
  always_ff @(posedge carrier_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_sync <= 3'b000;
      ack_tog  <= 1'b0;
      live     <= '{bit_cycles: DIV128_BIT_RATE, enc: ENC_NRZ, fsk: 1'b1};
    end else begin
      req_sync <= {req_sync[1:0], req_tog};
      if (req_sync[2] != req_sync[1]) begin
        live    <= settings_hold;
        ack_tog <= req_sync[1];
      end
    end
  end

  // bit timing from the carrier only
  ptr_bit_timer u_timer (
    .clk        (carrier_clock),
    .rst_n      (link_rst_n),
    .bit_cycles (live.bit_cycles),
    .bit_start  (bit_start),
    .half_start (half_start)
  );

  // serial memory stream coded before modulation
  ptr_encoder u_encoder (
    .clk        (carrier_clock),
    .rst_n      (link_rst_n),
    .method     (live.enc),
    .bit_start  (bit_start),
    .half_start (half_start),
    .data       (mem_data),
    .level      (enc_level)
  );

  // memory advances one bit after each boundary
  always_ff @(posedge carrier_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mem_step <= 1'b0;
    end else begin
      mem_step <= bit_start;
    end
  end

  // fsk set length follows the coded level
  assign fsk_set = enc_level ? FSK_HIGH_SET : FSK_LOW_SET;

  // fsk set counter, realigned at each bit
  always_ff @(posedge carrier_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fsk_count <= '0;
    end else if (bit_start || fsk_count >= fsk_set - 4'h1) begin
      fsk_count <= '0;
    end else begin
      fsk_count <= fsk_count + 4'h1;
    end
  end

  // coil transistor drive: with fsk damped in second half of each set, else follows the coded level
  always_ff @(posedge carrier_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      coil_pad_short <= 1'b0;
    end else if (live.fsk) begin
      coil_pad_short <= (fsk_count >= {1'b0, fsk_set[3:1]});
    end else begin
      coil_pad_short <= enc_level;
    end
  end

endmodule
`default_nettype wire

// ==== verif/ptr_reader_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptr_reader_model (
  output logic carrier_clock,
  output logic field_present
);
  initial begin
    carrier_clock = 1'b0;
    field_present = 1'b1;
  end

  // carrier runs only while the field is on, so it stands still in a gap
  always #6 if (field_present) carrier_clock = ~carrier_clock;

  // field switched off for the given time, then restored
  task automatic gap(input int ns);
    field_present = 1'b0;
    #(ns);
    field_present = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== verif/ptr_tag_control_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptr_tag_control_assertions
  import ptr_pkg::*;
(
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             carrier_clock,
  input wire logic             supply_ok,
  input wire logic             field_present,
  input wire logic             prog_success,
  input wire logic             mem_step,
  input wire logic             gap_event,
  input wire logic             anticoll_mode,
  input wire logic             array_lock_bit,
  input wire logic             prog_allow,
  input wire logic [CFG_W-1:0] cfg_effective
);
  logic [12:0] low_cnt;
  logic        gap_seen;
  logic [7:0]  step_cnt;
  logic        step_ok;

  // run length of field-off samples and whether this gap already flagged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt  <= '0;
      gap_seen <= 1'b0;
    end else begin
      low_cnt  <= field_present ? '0 : ((low_cnt == 13'h1fff) ? low_cnt : low_cnt + 13'h1);
      gap_seen <= field_present ? 1'b0 : (gap_seen | gap_event);
    end
  end

  // carrier cycles since the last memory step
  always_ff @(posedge carrier_clock or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt <= 8'h0;
      step_ok  <= 1'b0;
    end else if (mem_step) begin
      step_cnt <= 8'h1;
      step_ok  <= 1'b1;
    end else if (step_cnt != 8'hff) begin
      step_cnt <= step_cnt + 8'h1;
    end
  end

  gap_late_a: assert property (@(posedge clk) disable iff (!arst_n)
    gap_event |-> (low_cnt >= 13'd2995 && low_cnt <= 13'd3010)) else $error("gap flagged at wrong count");
  gap_due_a: assert property (@(posedge clk) disable iff (!arst_n)
    (low_cnt == 13'd3012) |-> gap_seen) else $error("gap not flagged");
  gap_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    gap_event |=> !gap_event) else $error("gap event longer than one cycle");
  gap_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
    gap_event |=> anticoll_mode [*3]) else $error("anticollision mode not entered");
  supply_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!supply_ok) [*4] |-> !prog_allow && !array_lock_bit) else $error("logic active without supply");
  lock_take_a: assert property (@(posedge clk) disable iff (!arst_n)
    prog_success && prog_allow |=> array_lock_bit && !prog_allow) else $error("lock not set");
  lock_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    array_lock_bit |=> array_lock_bit && !prog_allow) else $error("lock lost or programming allowed");
  fixed_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    prog_allow || array_lock_bit |-> cfg_effective[10] && (cfg_effective[11] == array_lock_bit))
    else $error("config top bits wrong");
  cfg_frozen_a: assert property (@(posedge clk) disable iff (!arst_n)
    (prog_allow || array_lock_bit) && $past(prog_allow || array_lock_bit) |-> $stable(cfg_effective[9:0]))
    else $error("config word changed");
  step_pulse_a: assert property (@(posedge carrier_clock) disable iff (!arst_n)
    mem_step |=> !mem_step) else $error("memory step too long");
  step_len_a: assert property (@(posedge carrier_clock) disable iff (!arst_n)
    mem_step && step_ok |-> step_cnt >= 8'h10) else $error("bit period too short");

  gap_seen_c: cover property (@(posedge clk) disable iff (!arst_n) gap_event);
  lock_take_c: cover property (@(posedge clk) disable iff (!arst_n) prog_success && prog_allow);
  locked_step_c: cover property (@(posedge carrier_clock) disable iff (!arst_n) mem_step && array_lock_bit);
endmodule

bind ptr_tag_control ptr_tag_control_assertions u_chk (.clk, .arst_n, .carrier_clock, .supply_ok,
  .field_present, .prog_success, .mem_step, .gap_event, .anticoll_mode, .array_lock_bit, .prog_allow,
  .cfg_effective);
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ptr_pkg::*;
  logic             clk          = 1'b0;
  logic             arst_n       = 1'b0;
  logic             supply_ok    = 1'b0;
  logic [CFG_W-1:0] cfg_word     = '0;
  logic             prog_success = 1'b0;
  logic             mem_data     = 1'b0;
  logic [CFG_W-1:0] w;
  wire logic        carrier_clock, field_present, mem_step, coil_pad_short;
  wire logic        gap_event, anticoll_mode, array_lock_bit, prog_allow;
  wire logic [CFG_W-1:0] cfg_effective;
  int               errors       = 0;
  int               n_compared   = 0;
  int               gap_count    = 0;
  int               seed         = 32'h5d243cd8;

  always #5 clk = ~clk;
  always @(negedge clk) if (gap_event === 1'b1) gap_count++;

  // whole-run limit so a stalled link cannot hang the regression
  initial begin
    #900000;
    errors++;
    $display("[FAIL] run time expected below limit seen timeout");
    end_sim();
  end

  ptr_reader_model reader (.carrier_clock, .field_present);
  ptr_tag_control dut (.clk, .arst_n, .carrier_clock, .supply_ok, .field_present, .cfg_word, .prog_success,
    .mem_data, .mem_step, .coil_pad_short, .gap_event, .anticoll_mode, .array_lock_bit, .prog_allow,
    .cfg_effective);

  task automatic end_sim;
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [CFG_W-1:0] exp, input logic [CFG_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bit length for a rate code {bit4,bit3,bit2}
  function automatic int rate_len(input logic [2:0] c);
    case (c)
      3'h6: return 32;
      3'h5: return 50;
      3'h0: return 128;
      3'h1: return 100;
      3'h2: return 80;
      3'h3: return 64;
      3'h4: return 40;
      default: return 16;
    endcase
  endfunction

  // reset with supply held low for a while, then power good
  task automatic boot(input logic [CFG_W-1:0] word);
    @(negedge clk);
    arst_n = 1'b0;
    supply_ok = 1'b0;
    cfg_word = word;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk_bit("prog_allow without supply", 1'b0, prog_allow);
    supply_ok = 1'b1;
    repeat (12) @(negedge clk);
  endtask

  task automatic wait_step;
    int n;
    n = 0;
    do begin
      @(negedge carrier_clock);
      n++;
      if (n > 400) begin
        errors++;
        $display("[FAIL] mem_step expected 1 seen %b", mem_step);
        end_sim();
      end
    end while (mem_step !== 1'b1);
  endtask

  // random bits; exact period, half-bit levels for direct modulation, set pattern for fsk
  task automatic run_bits(input int p, input logic [1:0] enc, input logic ask, input int nbits);
    logic d, cur, h1, h2, last, e1, e2;
    int   s;
    cur = 1'b0;
    last = 1'b0;
    wait_step();
    wait_step();
    for (int i = 0; i < nbits; i++) begin
      d = cur;
      cur = 1'($random(seed));
      mem_data = cur;
      // fsk: sets of 10 cycles for one, 8 for zero, damped in the second half
      s = d ? 10 : 8;
      for (int j = 1; j <= p; j++) begin
        @(negedge carrier_clock);
        if (j == p / 4) h1 = coil_pad_short;
        if (j == 3 * p / 4) h2 = coil_pad_short;
        chk_bit("mem_step", j == p, mem_step);
        if (!ask && i > 0) chk_bit("coil fsk", ((j - 1) % s) >= s / 2, coil_pad_short);
      end
      case (enc)
        ENC_BIPHASE_S:      e1 = ~last;
        ENC_INV_MANCHESTER: e1 = ~d;
        default:            e1 = d;
      endcase
      e2 = (enc == ENC_NRZ || (enc == ENC_BIPHASE_S && d)) ? e1 : ~e1;
      if (ask && i > 0) begin
        chk_bit("coil first half", e1, h1);
        chk_bit("coil second half", e2, h2);
      end
      last = h2;
    end
  endtask

  initial begin
    // blank device whose pins ask for a fast rate
    w = 12'($random(seed));
    w[11:10] = 2'b00;
    w[8:7] = 2'b01;
    w[3:1] = 3'h6;
    boot(w);
    chk_word("cfg_effective", w | 12'h400, cfg_effective);
    chk_bit("prog_allow", 1'b1, prog_allow);
    chk_bit("array_lock_bit", 1'b0, array_lock_bit);
    cfg_word = ~w;
    repeat (4) @(negedge clk);
    chk_word("cfg_effective frozen", w | 12'h400, cfg_effective);
    run_bits(128, ENC_NRZ, 1'b0, 3);
    @(negedge clk);
    prog_success = 1'b1;
    @(negedge clk);
    prog_success = 1'b0;
    chk_bit("array_lock_bit", 1'b1, array_lock_bit);
    chk_bit("prog_allow", 1'b0, prog_allow);
    chk_word("cfg_effective locked", w | 12'hc00, cfg_effective);
    repeat (4) begin
      @(negedge clk);
      prog_success = 1'($random(seed));
    end
    prog_success = 1'b0;
    chk_bit("array_lock_bit kept", 1'b1, array_lock_bit);
    run_bits(32, w[6:5], 1'b1, 4);
    // short gap must not count, a full gap must
    @(negedge clk);
    reader.gap(20000);
    repeat (10) @(negedge clk);
    chk_bit("anticoll_mode short gap", 1'b0, anticoll_mode);
    reader.gap(60000);
    repeat (10) @(negedge clk);
    chk_bit("anticoll_mode", 1'b1, anticoll_mode);
    chk_word("gap events", 12'h1, 12'(gap_count));
    // factory-locked parts, every encoding, then fsk with direct coding, corner and random rates
    for (int e = 0; e < 5; e++) begin
      w = 12'($random(seed));
      w[11:10] = 2'b10;
      w[8:7] = (e == 4) ? 2'b00 : 2'b01;
      w[6:5] = 2'(e);
      if (e < 2) w[3:1] = (e == 0) ? 3'h6 : 3'h7;
      boot(w);
      chk_bit("array_lock_bit", 1'b1, array_lock_bit);
      chk_bit("prog_allow", 1'b0, prog_allow);
      run_bits(rate_len(w[3:1]), w[6:5], e < 4, 5);
    end
    end_sim();
  end
endmodule
`default_nettype wire
